//--- twbc_pkg.sv
/*
  Constants for the two-wire bus controller: register port offsets, control
  field positions, reset values, status codes, clock divider table, states.
  Assumes it is compiled before every other file of the block.
*/
package twbc_pkg;

  // Register port offsets
  localparam logic [7:0] TWBC_ADR_OWN  = 8'hD1;
  localparam logic [7:0] TWBC_ADR_BYTE = 8'hD2;
  localparam logic [7:0] TWBC_ADR_STAT = 8'hD3;
  localparam logic [7:0] TWBC_ADR_CTRL = 8'hD4;

  // bus_control field positions, and the general call enable bit of the own address
  localparam int TWBC_CB_RATE2  = 7;
  localparam int TWBC_CB_ENABLE = 6;
  localparam int TWBC_CB_BEGIN  = 5;
  localparam int TWBC_CB_END    = 4;
  localparam int TWBC_CB_EVENT  = 3;
  localparam int TWBC_CB_ACK    = 2;
  localparam int TWBC_CB_RATE1  = 1;
  localparam int TWBC_CB_RATE0  = 0;
  localparam int TWBC_OA_GCE    = 0;

  // Reset values
  localparam logic [7:0] TWBC_CTRL_RST = 8'h00;
  localparam logic [7:0] TWBC_OWN_RST  = 8'h00;
  localparam logic [7:0] TWBC_BYTE_RST = 8'h00;

  // Status codes
  localparam logic [7:0] TWBC_ST_BUSERR  = 8'h00;
  localparam logic [7:0] TWBC_ST_START   = 8'h08;
  localparam logic [7:0] TWBC_ST_RSTART  = 8'h10;
  localparam logic [7:0] TWBC_ST_AW_ACK  = 8'h18;
  localparam logic [7:0] TWBC_ST_AW_NAK  = 8'h20;
  localparam logic [7:0] TWBC_ST_DW_ACK  = 8'h28;
  localparam logic [7:0] TWBC_ST_DW_NAK  = 8'h30;
  localparam logic [7:0] TWBC_ST_ARBLOST = 8'h38;
  localparam logic [7:0] TWBC_ST_AR_ACK  = 8'h40;
  localparam logic [7:0] TWBC_ST_AR_NAK  = 8'h48;
  localparam logic [7:0] TWBC_ST_DR_ACK  = 8'h50;
  localparam logic [7:0] TWBC_ST_DR_NAK  = 8'h58;
  localparam logic [7:0] TWBC_ST_SW_OWN  = 8'h60;
  localparam logic [7:0] TWBC_ST_SW_LOST = 8'h68;
  localparam logic [7:0] TWBC_ST_GC_OWN  = 8'h70;
  localparam logic [7:0] TWBC_ST_GC_LOST = 8'h78;
  localparam logic [7:0] TWBC_ST_SD_ACK  = 8'h80;
  localparam logic [7:0] TWBC_ST_SD_NAK  = 8'h88;
  localparam logic [7:0] TWBC_ST_GD_ACK  = 8'h90;
  localparam logic [7:0] TWBC_ST_GD_NAK  = 8'h98;
  localparam logic [7:0] TWBC_ST_SSTOP   = 8'hA0;
  localparam logic [7:0] TWBC_ST_SR_OWN  = 8'hA8;
  localparam logic [7:0] TWBC_ST_SR_LOST = 8'hB0;
  localparam logic [7:0] TWBC_ST_ST_ACK  = 8'hB8;
  localparam logic [7:0] TWBC_ST_ST_NAK  = 8'hC0;
  localparam logic [7:0] TWBC_ST_ST_LAST = 8'hC8;
  localparam logic [7:0] TWBC_ST_NONE    = 8'hF8;

  // Half serial clock period in link clocks, indexed by the rate field
  localparam logic [8:0] TWBC_HALF_TBL [0:7] = '{
    9'h008, 9'h010, 9'h018, 9'h020, 9'h030, 9'h040, 9'h080, 9'h100
  };
  localparam logic [3:0] TWBC_BIT_ACK = 4'h8;

  typedef enum logic [4:0] {
    TWBC_S_IDLE  = 5'h01,
    TWBC_S_START = 5'h02,
    TWBC_S_BIT   = 5'h04,
    TWBC_S_HOLD  = 5'h08,
    TWBC_S_STOP  = 5'h10
  } twbc_state_e;

endpackage

//--- twbc_sync.sv
/*
  Two flip-flop level synchroniser with a chosen reset value.
  Assumes each bit is a level that stays put long enough to be seen.
*/
module twbc_sync #(
  parameter int           W  = 1,
  parameter logic [W-1:0] RV = '0
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Level in, synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RV;
      q      <= RV;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

//--- twbc_controller.sv
/*
  Two-wire bus controller: register port on sys_clk, bus engine on link_clk.
  Assumes open-drain pins resolved outside (oe high pulls low) and pull-ups.
*/
module twbc_controller
  import twbc_pkg::*;
(
  // System clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Bus side
  input  wire logic       link_clk,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Resets and crossings

  logic        rst_sys_n, rst_lk_n;
  logic [7:0]  ctrl_r, own_r, byte_r, stat_r;
  logic        go_tgl_r, evt_tgl_r, sc_tgl_r, evt_p_r, sc_p_r, go_p_r;
  logic [1:0]  lk_s;
  logic [7:0]  cs, own_s;
  logic [1:0]  pin_s;
  logic [7:0]  stat_lk_r, sh_r;

  twbc_sync #(.W(1), .RV(1'b0)) u_rst_sys (
    .clk(sys_clk), .rst_n(reset_n), .d(1'b1), .q(rst_sys_n));
  twbc_sync #(.W(1), .RV(1'b0)) u_rst_lk (
    .clk(link_clk), .rst_n(reset_n), .d(1'b1), .q(rst_lk_n));
  twbc_sync #(.W(2), .RV(2'b00)) u_lk2sys (
    .clk(sys_clk), .rst_n(rst_sys_n), .d({evt_tgl_r, sc_tgl_r}), .q(lk_s));
  twbc_sync #(.W(8), .RV(8'h00)) u_ctl2lk (
    .clk(link_clk), .rst_n(rst_lk_n),
    .d({go_tgl_r, ctrl_r[TWBC_CB_ENABLE], ctrl_r[TWBC_CB_BEGIN], ctrl_r[TWBC_CB_END],
        ctrl_r[TWBC_CB_ACK], ctrl_r[TWBC_CB_RATE2], ctrl_r[TWBC_CB_RATE1],
        ctrl_r[TWBC_CB_RATE0]}),
    .q(cs));
  twbc_sync #(.W(8), .RV(8'h00)) u_own2lk (
    .clk(link_clk), .rst_n(rst_lk_n), .d(own_r), .q(own_s));
  twbc_sync #(.W(2), .RV(2'b11)) u_pins (
    .clk(link_clk), .rst_n(rst_lk_n), .d({scl_i, sda_i}), .q(pin_s));

  ////////////////////////////////////////////////////////////////////////////
  // Register side (sys_clk)

  logic evt_pls, sc_pls, wr_ctrl;
  assign evt_pls = lk_s[1] ^ evt_p_r;
  assign sc_pls  = lk_s[0] ^ sc_p_r;
  assign wr_ctrl = sfr_wr && (sfr_addr == TWBC_ADR_CTRL);

  always_ff @(posedge sys_clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      evt_p_r <= 1'b0;
      sc_p_r  <= 1'b0;
    end else begin
      evt_p_r <= lk_s[1];
      sc_p_r  <= lk_s[0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      ctrl_r <= TWBC_CTRL_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= sfr_wdata;
      // A completion landing with a software clear keeps the flag set
      if (evt_pls) ctrl_r[TWBC_CB_EVENT] <= 1'b1;
      if ((sc_pls && !(wr_ctrl && sfr_wdata[TWBC_CB_END])) || !ctrl_r[TWBC_CB_ENABLE])
        ctrl_r[TWBC_CB_END] <= 1'b0;
    end
  end

  // Clearing a set event flag hands the next action to the engine
  always_ff @(posedge sys_clk or negedge rst_sys_n) begin
    if (!rst_sys_n) go_tgl_r <= 1'b0;
    else if (wr_ctrl && ctrl_r[TWBC_CB_EVENT] && !sfr_wdata[TWBC_CB_EVENT] && !evt_pls)
      go_tgl_r <= ~go_tgl_r;
  end

  // Engine status is captured on each event pulse from the engine, the shift byte too unless the byte port is written in that cycle
  always_ff @(posedge sys_clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      stat_r <= TWBC_ST_NONE;
      byte_r <= TWBC_BYTE_RST;
      own_r  <= TWBC_OWN_RST;
    end else begin
      if (evt_pls) stat_r <= stat_lk_r;
      if (sfr_wr && sfr_addr == TWBC_ADR_BYTE) byte_r <= sfr_wdata;
      else if (evt_pls) byte_r <= sh_r;
      if (sfr_wr && sfr_addr == TWBC_ADR_OWN) own_r <= sfr_wdata;
    end
  end

  // Page selection is done outside, so a second instance needs only new pins
  always_ff @(posedge sys_clk or negedge rst_sys_n) begin
    if (!rst_sys_n) sfr_rdata <= 8'h00;
    else begin
      case (sfr_addr)
        TWBC_ADR_OWN:  sfr_rdata <= own_r;
        TWBC_ADR_BYTE: sfr_rdata <= byte_r;
        TWBC_ADR_STAT: sfr_rdata <= ctrl_r[TWBC_CB_EVENT] ? stat_r : TWBC_ST_NONE;
        TWBC_ADR_CTRL: sfr_rdata <= ctrl_r;
        default:       sfr_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus engine (link_clk)

  twbc_state_e st_r;
  logic        go_s, ens_s, sta_s, sto_s, aa_s, go_pls;
  logic        scl_s, sda_s, scl_p_r, sda_p_r, busy_r;
  logic        rise, fall, st_det, sp_det, mt_own, mt_gc, sc_req;
  logic [8:0]  half, cnt_r;
  logic [1:0]  ph_r;
  logic [3:0]  bit_r;
  logic        scl_drv_r, sda_drv_r, mst_r, part_r, lost_r, adr_r, tx_r, dir_r;
  logic        gc_r, last_r, ackd_r, ackin_r, fin_r, err_r, rep_r, rs_r;
  logic [7:0]  code_c;

  assign {go_s, ens_s, sta_s, sto_s, aa_s} = cs[7:3];
  assign {scl_s, sda_s} = pin_s;
  assign go_pls = go_s ^ go_p_r;
  assign half   = TWBC_HALF_TBL[cs[2:0]];
  assign rise   = scl_s && !scl_p_r;
  assign fall   = !scl_s && scl_p_r;
  assign st_det = scl_s && scl_p_r && sda_p_r && !sda_s;
  assign sp_det = scl_s && scl_p_r && !sda_p_r && sda_s;
  assign mt_own = aa_s && (sh_r[7:1] == own_s[7:1]);
  assign mt_gc  = aa_s && own_s[TWBC_OA_GCE] && (sh_r == 8'h00);
  assign sc_req = sp_det || (st_r == TWBC_S_HOLD && go_pls && err_r && sto_s);
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_drv_r;
  assign sda_oe = sda_drv_r;

  always_ff @(posedge link_clk or negedge rst_lk_n) begin
    if (!rst_lk_n) begin
      scl_p_r  <= 1'b1;
      sda_p_r  <= 1'b1;
      go_p_r   <= 1'b0;
      busy_r   <= 1'b0;
      sc_tgl_r <= 1'b0;
    end else begin
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
      go_p_r  <= go_s;
      if (!ens_s || sp_det) busy_r <= 1'b0;
      else if (st_det) busy_r <= 1'b1;
      if (sc_req) sc_tgl_r <= ~sc_tgl_r;
    end
  end

  // Status for a finished byte
  always_comb begin
    if (lost_r && !part_r) code_c = TWBC_ST_ARBLOST;
    else if (adr_r) begin
      if (mst_r && dir_r) code_c = ackin_r ? TWBC_ST_AR_NAK : TWBC_ST_AR_ACK;
      else if (mst_r) code_c = ackin_r ? TWBC_ST_AW_NAK : TWBC_ST_AW_ACK;
      else if (lost_r)
        code_c = gc_r ? TWBC_ST_GC_LOST : (dir_r ? TWBC_ST_SR_LOST : TWBC_ST_SW_LOST);
      else code_c = gc_r ? TWBC_ST_GC_OWN : (dir_r ? TWBC_ST_SR_OWN : TWBC_ST_SW_OWN);
    end else if (mst_r && tx_r) code_c = ackin_r ? TWBC_ST_DW_NAK : TWBC_ST_DW_ACK;
    else if (mst_r) code_c = ackd_r ? TWBC_ST_DR_ACK : TWBC_ST_DR_NAK;
    else if (tx_r)
      code_c = ackin_r ? TWBC_ST_ST_NAK : (last_r ? TWBC_ST_ST_LAST : TWBC_ST_ST_ACK);
    else if (gc_r) code_c = ackd_r ? TWBC_ST_GD_ACK : TWBC_ST_GD_NAK;
    else code_c = ackd_r ? TWBC_ST_SD_ACK : TWBC_ST_SD_NAK;
  end

  always_ff @(posedge link_clk or negedge rst_lk_n) begin
    if (!rst_lk_n) begin
      st_r <= TWBC_S_IDLE;  ph_r <= 2'd0;  cnt_r <= 9'h000;  bit_r <= 4'h0;
      sh_r <= 8'h00;  stat_lk_r <= TWBC_ST_NONE;  evt_tgl_r <= 1'b0;
      scl_drv_r <= 1'b0;  sda_drv_r <= 1'b0;  mst_r <= 1'b0;  part_r <= 1'b0;
      lost_r <= 1'b0;  adr_r <= 1'b0;  tx_r <= 1'b0;  dir_r <= 1'b0;  gc_r <= 1'b0;
      last_r <= 1'b0;  ackd_r <= 1'b0;  ackin_r <= 1'b1;  fin_r <= 1'b0;
      err_r <= 1'b0;  rep_r <= 1'b0;  rs_r <= 1'b0;
    end else if (!ens_s) begin
      st_r <= TWBC_S_IDLE;  scl_drv_r <= 1'b0;  sda_drv_r <= 1'b0;
      mst_r <= 1'b0;  part_r <= 1'b0;  err_r <= 1'b0;  fin_r <= 1'b0;
    end else begin
      if (cnt_r != 9'h000) cnt_r <= cnt_r - 9'h001;
      case (st_r)
        TWBC_S_IDLE: begin
          scl_drv_r <= 1'b0;
          sda_drv_r <= 1'b0;
          if (st_det) begin
            st_r <= TWBC_S_BIT;  adr_r <= 1'b1;  mst_r <= 1'b0;  part_r <= 1'b0;
            lost_r <= 1'b0;  tx_r <= 1'b0;  sh_r <= 8'hFF;  bit_r <= 4'h0;  rs_r <= 1'b0;
          end else if (sta_s && !busy_r) begin
            st_r <= TWBC_S_START;  ph_r <= 2'd0;  cnt_r <= half;  mst_r <= 1'b1;
            part_r <= 1'b1;  lost_r <= 1'b0;  rep_r <= 1'b0;
          end
        end
        TWBC_S_START: begin
          case (ph_r)
            2'd0: begin
              sda_drv_r <= 1'b0;
              if (cnt_r == 9'h000) begin scl_drv_r <= 1'b0; ph_r <= 2'd1; cnt_r <= half; end
            end
            2'd1: begin
              if (!scl_s) cnt_r <= half;
              else if (cnt_r == 9'h000) begin sda_drv_r <= 1'b1; ph_r <= 2'd2; cnt_r <= half; end
            end
            2'd2: if (cnt_r == 9'h000) begin scl_drv_r <= 1'b1; ph_r <= 2'd3; cnt_r <= half; end
            default: if (cnt_r == 9'h000) begin
              stat_lk_r <= rep_r ? TWBC_ST_RSTART : TWBC_ST_START;
              evt_tgl_r <= ~evt_tgl_r;
              st_r <= TWBC_S_HOLD;  rep_r <= 1'b1;  adr_r <= 1'b1;  tx_r <= 1'b1;
            end
          endcase
        end
        TWBC_S_BIT: begin
          // Master clock: low half counted from any observed fall, high half from
          // the observed rise, so a slower device stretches us and a faster one shortens us
          if (mst_r) begin
            if (fall) begin scl_drv_r <= 1'b1; cnt_r <= half; end
            else if (scl_drv_r && cnt_r == 9'h000) scl_drv_r <= 1'b0;
            else if (!scl_drv_r && rise) cnt_r <= half;
            // Reload here so the low half is not cut short before our fall is seen
            else if (!scl_drv_r && scl_s && cnt_r == 9'h000) begin
              scl_drv_r <= 1'b1;
              cnt_r     <= half;
            end
          end
          if (rise) begin
            rs_r <= 1'b1;
            if (bit_r != TWBC_BIT_ACK) begin
              sh_r <= {sh_r[6:0], sda_s};
              if (mst_r && tx_r && !sda_drv_r && !sda_s) begin
                lost_r <= 1'b1;  mst_r <= 1'b0;  tx_r <= 1'b0;  scl_drv_r <= 1'b0;
              end
            end else ackin_r <= sda_s;
          end
          if (fall && rs_r) begin
            rs_r <= 1'b0;
            if (bit_r == TWBC_BIT_ACK) begin
              stat_lk_r <= code_c;
              evt_tgl_r <= ~evt_tgl_r;
              st_r <= TWBC_S_HOLD;
              sda_drv_r <= 1'b0;
              scl_drv_r <= mst_r || part_r;
              adr_r <= 1'b0;
              if (adr_r && mst_r) tx_r <= !dir_r;
              fin_r <= (lost_r && !part_r) || (!mst_r && (tx_r ? (ackin_r || last_r) : !ackd_r));
            end else begin
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h7) begin
                if (adr_r) dir_r <= sh_r[0];
                if (adr_r && !mst_r) begin
                  if (mt_own || mt_gc) begin
                    part_r <= 1'b1;  gc_r <= mt_gc;  tx_r <= sh_r[0] && !mt_gc;
                    sda_drv_r <= 1'b1;  ackd_r <= 1'b1;
                  end else begin
                    sda_drv_r <= 1'b0;
                    if (!lost_r) st_r <= TWBC_S_IDLE;
                  end
                end else sda_drv_r <= !tx_r && ackd_r;
              end else sda_drv_r <= tx_r && !sh_r[7];
            end
          end
          // START or STOP on the bus while a byte is under way
          if (st_det || sp_det) begin
            if (bit_r == 4'h0 && part_r && !mst_r) begin
              stat_lk_r <= TWBC_ST_SSTOP;  evt_tgl_r <= ~evt_tgl_r;  st_r <= TWBC_S_HOLD;
              part_r <= 1'b0;  fin_r <= 1'b1;  scl_drv_r <= 1'b0;  sda_drv_r <= 1'b0;
            end else if (bit_r == 4'h0 && !mst_r && st_det) begin
              adr_r <= 1'b1;  sh_r <= 8'hFF;  tx_r <= 1'b0;  rs_r <= 1'b0;
            end else if (mst_r || part_r) begin
              stat_lk_r <= TWBC_ST_BUSERR;  evt_tgl_r <= ~evt_tgl_r;
              st_r <= TWBC_S_HOLD;  err_r <= 1'b1;  scl_drv_r <= 1'b0;  sda_drv_r <= 1'b0;
            end else st_r <= TWBC_S_IDLE;
          end
        end
        TWBC_S_HOLD: if (go_pls) begin
          if (err_r || fin_r || !(mst_r || part_r)) begin
            st_r <= TWBC_S_IDLE;  err_r <= 1'b0;  fin_r <= 1'b0;  part_r <= 1'b0;
            mst_r <= 1'b0;  scl_drv_r <= 1'b0;  sda_drv_r <= 1'b0;
          end else if (mst_r && sta_s) begin
            st_r <= TWBC_S_START;  ph_r <= 2'd0;  cnt_r <= half;
          end else if (mst_r && sto_s) begin
            st_r <= TWBC_S_STOP;  ph_r <= 2'd0;  cnt_r <= half;  sda_drv_r <= 1'b1;
          end else begin
            st_r <= TWBC_S_BIT;  bit_r <= 4'h0;  rs_r <= 1'b0;  cnt_r <= half;
            sh_r <= tx_r ? byte_r : 8'hFF;
            sda_drv_r <= tx_r && !byte_r[7];
            ackd_r <= aa_s;
            last_r <= !aa_s;
            if (!mst_r) scl_drv_r <= 1'b0;
          end
        end
        TWBC_S_STOP: begin
          case (ph_r)
            2'd0: if (cnt_r == 9'h000) begin scl_drv_r <= 1'b0; ph_r <= 2'd1; cnt_r <= half; end
            2'd1: begin
              if (!scl_s) cnt_r <= half;
              else if (cnt_r == 9'h000) begin sda_drv_r <= 1'b0; ph_r <= 2'd2; cnt_r <= half; end
            end
            default: if (cnt_r == 9'h000) begin
              st_r <= TWBC_S_IDLE;  mst_r <= 1'b0;  part_r <= 1'b0;
            end
          endcase
        end
        default: st_r <= TWBC_S_IDLE;
      endcase
    end
  end

endmodule

//--- twbc_properties.sv
/* Port checker for the two-wire bus controller.
   Assumes it is bound to every controller instance. */
module twbc_properties
  import twbc_pkg::*;
(
  // Register side
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Bus side
  input wire logic       link_clk,
  input wire logic       scl_i,
  input wire logic       scl_o,
  input wire logic       scl_oe,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe
);
  sequence s_wr_rd(logic [7:0] a);
    sfr_wr && sfr_addr == a ##1 !sfr_wr && sfr_addr == a;
  endsequence
  sequence s_start;
    $rose(sda_oe) && scl_i && !scl_oe;
  endsequence
  AST_OWN_RB: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_wr_rd(TWBC_ADR_OWN) |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("own rb");
  AST_CTRL_RB: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_wr_rd(TWBC_ADR_CTRL) |=> (sfr_rdata & 8'hE7) == ($past(sfr_wdata, 2) & 8'hE7))
    else $error("ctrl rb");
  AST_HOLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(sfr_addr inside {[8'hD1:8'hD4]}) |=> sfr_rdata == 8'h00) else $error("hole");
  AST_STAT_ALN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sfr_addr == TWBC_ADR_STAT |=> sfr_rdata[2:0] == 3'h0) else $error("code");
  AST_STAT_NONE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sfr_wr && sfr_addr == TWBC_ADR_CTRL && sfr_wdata[6:3] == 4'h0 ##1 !sfr_wr
    ##1 sfr_addr == TWBC_ADR_STAT |=> sfr_rdata == TWBC_ST_NONE) else $error("F8");
  AST_PINS: assert property (@(posedge link_clk) disable iff (!reset_n)
    !scl_o && !sda_o) else $error("pin level");
  // Shortest divider is 8 link clocks per half period
  AST_SCL_LOW: assert property (@(posedge link_clk) disable iff (!reset_n)
    $rose(scl_oe) |-> scl_oe[*8]) else $error("scl low short");
  AST_START: assert property (@(posedge link_clk) disable iff (!reset_n)
    s_start |-> !scl_oe[*4] ##[1:600] scl_oe) else $error("start");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind twbc_controller twbc_properties i_props (.sys_clk, .reset_n, .sfr_addr, .sfr_wr,
  .sfr_wdata, .sfr_rdata, .link_clk, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe);

//--- twbc_peer_slave.sv
/* Peer slave: acknowledges its address, keeps written bytes, returns tx_byte.
   Assumes wires resolved with pull-ups outside. */
module twbc_peer_slave #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // Resolved wires
  input  wire logic       scl,
  input  wire logic       sda,
  // Data and drives
  input  wire logic [7:0] tx_byte,
  input  wire logic       stall,
  output logic      [7:0] rx_byte,
  output logic            scl_oe,
  output logic            sda_oe
);
  logic [3:0] n = 4'h0;
  logic [7:0] sh = 8'h00;
  logic       sel = 1'b0;
  logic       rd = 1'b0;
  logic       first = 1'b0;
  initial sda_oe = 1'b0;
  initial rx_byte = 8'h00;
  assign scl_oe = stall;
  always @(sda) if (scl === 1'b1) begin
    n = 4'h0;
    first = !sda;
    sel = 1'b0;
    sda_oe = 1'b0;
  end
  always @(posedge scl) begin
    if (n < 4'h8) sh = {sh[6:0], sda};
    n = n + 4'h1;
    if (n == 4'h8 && !first && sel && !rd) rx_byte = sh;
    // A refused byte ends the read so the master can send STOP
    if (n == 4'h9 && rd && !first && sda) sel = 1'b0;
  end
  always @(negedge scl) begin
    if (n == 4'h9) begin
      n = 4'h0;
      first = 1'b0;
    end
    if (n == 4'h8 && first) begin
      sel = sh[7:1] == ADDR;
      rd = sh[0];
    end
    if (sel && rd && !first) sda_oe = n < 4'h8 && !tx_byte[3'h7 - n[2:0]];
    else sda_oe = n == 4'h8 && sel;
  end
endmodule

//--- two_wire_bus_controller_tb_top.sv
/* Bench: register checks, then master traffic against the peer slave.
   Assumes pull-ups on both wires. */
module two_wire_bus_controller_tb_top
  import twbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] PEER = 7'h2A;
  logic       sys_clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, stall = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, tx_byte = 8'h00, sfr_rdata, rx_byte, d, q;
  logic       scl_oe, sda_oe, p_scl_oe, p_sda_oe;
  wire        scl = !(scl_oe | p_scl_oe);
  wire        sda = !(sda_oe | p_sda_oe);
  int         failures = 0;
  int         n_checks = 0;
  logic [31:0] seed = 32'h0000C798;
  logic [7:0] adr [5] = '{8'hD0, TWBC_ADR_OWN, TWBC_ADR_BYTE, TWBC_ADR_STAT, TWBC_ADR_CTRL};
  logic [7:0] rst [5] = '{8'h00, TWBC_OWN_RST, TWBC_BYTE_RST, TWBC_ST_NONE, TWBC_CTRL_RST};
  twbc_controller i_dut (.sys_clk, .reset_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
    .link_clk, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(), .sda_oe);
  twbc_peer_slave #(.ADDR(PEER)) i_peer (.scl, .sda, .tx_byte, .stall, .rx_byte,
    .scl_oe(p_scl_oe), .sda_oe(p_sda_oe));
  initial forever #50 sys_clk = !sys_clk;
  initial begin
    #7;
    forever #15 link_clk = !link_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // End bit is forced clear while the interface is off
  function automatic logic [7:0] ctrl_exp(logic [7:0] v);
    return v[TWBC_CB_ENABLE] ? v : v & 8'hEF;
  endfunction
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge sys_clk);
    #1 sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(posedge sys_clk);
    #1 sfr_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    #1 sfr_addr = a;
    @(posedge sys_clk);
    #1 v = sfr_rdata;
  endtask
  task automatic poll(int bit_no, logic want);
    logic [7:0] v;
    for (int i = 0; i < 3000; i++) begin
      rd(TWBC_ADR_CTRL, v);
      if (v[bit_no] === want) return;
    end
    failures++;
    print_verdict();
  endtask
  task automatic step(logic [7:0] ctl, logic [7:0] st);
    wr(TWBC_ADR_CTRL, ctl);
    poll(TWBC_CB_EVENT, 1'b1);
    rd(TWBC_ADR_STAT, q);
    check("status", q, st);
  endtask
  task automatic stop();
    wr(TWBC_ADR_CTRL, 8'h54);
    poll(TWBC_CB_END, 1'b0);
    check("lines", {6'h00, scl, sda}, 8'h03);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (adr[i]) begin
      rd(adr[i], q);
      check("reset", q, rst[i]);
    end
    repeat (20) begin
      d = rnd();
      wr(TWBC_ADR_OWN, d);
      rd(TWBC_ADR_OWN, q);
      check("own", q, d);
      d = rnd() & 8'h97;
      wr(TWBC_ADR_CTRL, d);
      rd(TWBC_ADR_CTRL, q);
      check("ctrl", q, ctrl_exp(d));
      rd(TWBC_ADR_STAT, q);
      check("idle status", q, TWBC_ST_NONE);
    end
    $display("test registers done");
    wr(TWBC_ADR_OWN, 8'h10);
    tx_byte = rnd();
    wr(TWBC_ADR_CTRL, 8'h44);
    step(8'h64, TWBC_ST_START);
    wr(TWBC_ADR_BYTE, {PEER, 1'b0});
    step(8'h44, TWBC_ST_AW_ACK);
    d = rnd();
    wr(TWBC_ADR_BYTE, d);
    stall = 1'b1;
    wr(TWBC_ADR_CTRL, 8'h44);
    repeat (20) @(posedge sys_clk);
    #1 stall = 1'b0;
    step(8'h44, TWBC_ST_DW_ACK);
    check("peer byte", rx_byte, d);
    step(8'h64, TWBC_ST_RSTART);
    wr(TWBC_ADR_BYTE, {PEER, 1'b1});
    step(8'h44, TWBC_ST_AR_ACK);
    step(8'h40, TWBC_ST_DR_NAK);
    rd(TWBC_ADR_BYTE, q);
    check("read byte", q, tx_byte);
    stop();
    $display("test master done");
    step(8'h65, TWBC_ST_START);
    wr(TWBC_ADR_BYTE, {~PEER, 1'b0});
    step(8'h45, TWBC_ST_AW_NAK);
    stop();
    $display("test refusal done");
    print_verdict();
  end
endmodule
